// ### include/table_access_consts.svh
// Constants for the program memory table access unit.
// Assumes inclusion by the package and the design file.
`ifndef TABLE_ACCESS_CONSTS_SVH
`define TABLE_ACCESS_CONSTS_SVH

`define PTR_WIDTH       22
`define ADDR_WIDTH      21
`define CFG_SPACE_BIT   21
`define HOLD_SEL_LSB    0
`define HOLD_SEL_MSB    4
`define BLOCK_LSB       6
`define BLOCK_MSB       21
`define HOLD_COUNT      32
`define LATCH_RESET     8'h00
`define PTR_RESET       22'h000000
`define HOLD_RESET      8'hff
`define SFR_ADDR_WIDTH  2
`define SFR_LATCH       2'h0
`define SFR_PTR_UPPER   2'h1
`define SFR_PTR_HIGH    2'h2
`define SFR_PTR_LOW     2'h3

`endif

// ### include/table_access_pkg.sv
// Types for the program memory table access unit.
// Assumes the constants header is on the include path.
`include "table_access_consts.svh"

package table_access_pkg;

  typedef enum logic [3:0]
  {
    PTR_KEEP     = 4'b0001,
    PTR_POST_INC = 4'b0010,
    PTR_POST_DEC = 4'b0100,
    PTR_PRE_INC  = 4'b1000
  } ptr_mode_type;

  typedef struct packed
  {
    logic         valid;
    logic         is_write;
    ptr_mode_type mode;
  } table_cmd_type;

  typedef struct packed
  {
    logic                      we;
    logic                      re;
    logic [`SFR_ADDR_WIDTH-1:0] addr;
    logic [7:0]                wdata;
  } sfr_req_type;

  typedef struct packed
  {
    logic                      req;
    logic [`ADDR_WIDTH-1:0]    addr;
    logic                      cfg_space;
  } flash_rd_type;

  typedef struct packed
  {
    logic                                    req;
    logic [`BLOCK_MSB-`BLOCK_LSB:0]          block;
    logic                                    cfg_space;
  } flash_blk_type;

endpackage

// ### hw/program_memory_table_access.sv
// Table access unit: data latch, byte pointer, write holding registers.
// Assumes the core issues one table command at a time and that the
// flash answers a read with rd_valid_i; all inputs are on clk_i.
`timescale 1ns/1ps
`include "table_access_consts.svh"

module program_memory_table_access
  import table_access_pkg::*;
#(
  parameter int HOLD_COUNT = `HOLD_COUNT
)
(
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   arst_n_i,
  // Special register access from the core
  input  wire sfr_req_type            sfr_i,
  output logic [7:0]                  sfr_rdata_o,
  // Table instruction from the core
  input  wire table_cmd_type          cmd_i,
  output logic                        cmd_busy_o,
  output logic                        cmd_done_o,
  // Write and erase control
  input  wire logic                   write_start_i,
  input  wire logic                   erase_start_i,
  input  wire logic                   flash_op_done_i,
  output logic                        write_active_o,
  // Flash read port
  output flash_rd_type                flash_rd_o,
  input  wire logic                   rd_valid_i,
  input  wire logic [7:0]             rd_data_i,
  // Flash block write and erase port
  output flash_blk_type               flash_wr_o,
  output flash_blk_type               flash_erase_o,
  output logic [HOLD_COUNT*8-1:0]     hold_data_o
);

  localparam int SEL_W = $clog2(HOLD_COUNT);

  // Elaboration checks: sizes the select, space and block fields cannot serve
  if (HOLD_COUNT != (1 << SEL_W) || SEL_W != `HOLD_SEL_MSB - `HOLD_SEL_LSB + 1)
  begin : g_hold_check
    $error("HOLD_COUNT must match the holding select field");
  end
  if (`PTR_WIDTH != `ADDR_WIDTH + 1 || `CFG_SPACE_BIT != `ADDR_WIDTH)
  begin : g_space_check
    $error("Pointer must be the byte address plus one space bit");
  end
  if (`BLOCK_MSB != `PTR_WIDTH - 1 || `PTR_WIDTH - 16 > 8)
  begin : g_field_check
    $error("Block field or upper pointer byte does not fit the pointer");
  end
  if (`SFR_ADDR_WIDTH != 2)
  begin : g_map_check
    $error("Four registers need a two-bit register select");
  end

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_DONE = 3'b100
  } state_type;

  state_type                    state;
  state_type                    next_state;
  logic [7:0]                   latch;
  logic [7:0]                   next_latch;
  logic [`PTR_WIDTH-1:0]        ptr;
  logic [`PTR_WIDTH-1:0]        next_ptr;
  ptr_mode_type                 mode;
  ptr_mode_type                 next_mode;
  logic                         write_bit;
  logic                         next_write_bit;
  logic [7:0]                   hold [HOLD_COUNT];
  logic [7:0]                   next_hold [HOLD_COUNT];
  logic [`ADDR_WIDTH-1:0]       ptr_inc;
  logic [`ADDR_WIDTH-1:0]       ptr_dec;
  logic [`PTR_WIDTH-1:0]        xfer_ptr;
  logic [`PTR_WIDTH-1:0]        sfr_ptr;
  flash_blk_type                next_wr;
  flash_blk_type                next_erase;
  flash_rd_type                 next_rd;
  logic                         cmd_take;
  logic                         hold_write;
  logic [SEL_W-1:0]             hold_sel;
  logic [7:0]                   ptr_upper_byte;
  logic [`BLOCK_MSB-`BLOCK_LSB:0] block_sel;

  // Only the low 21 bits step; the space bit stays put
  assign ptr_inc = ptr[`ADDR_WIDTH-1:0] + `ADDR_WIDTH'(1);
  assign ptr_dec = ptr[`ADDR_WIDTH-1:0] - `ADDR_WIDTH'(1);

  // A command is taken only while idle; valid while busy is dropped
  assign cmd_take   = (state == ST_IDLE) && cmd_i.valid;
  assign hold_write = cmd_take && cmd_i.is_write;
  assign hold_sel   = xfer_ptr[`HOLD_SEL_MSB:`HOLD_SEL_LSB];

  // Upper byte pads its two unused top bits with zero
  assign ptr_upper_byte = 8'(ptr[`PTR_WIDTH-1:16]);

  // Block target ignores the offset bits below the block boundary
  assign block_sel = ptr[`BLOCK_MSB:`BLOCK_LSB];

  // Pointer as written through the special registers
  always_comb
  begin
    sfr_ptr = ptr;
    if (sfr_i.we)
    begin
      case (sfr_i.addr)
        `SFR_PTR_UPPER: sfr_ptr[`PTR_WIDTH-1:16] = sfr_i.wdata[`PTR_WIDTH-17:0];
        `SFR_PTR_HIGH:  sfr_ptr[15:8] = sfr_i.wdata;
        `SFR_PTR_LOW:   sfr_ptr[7:0] = sfr_i.wdata;
        default:        sfr_ptr = ptr;
      endcase
    end
  end

  // Address used for this transfer
  always_comb
  begin
    if (cmd_i.mode == PTR_PRE_INC)
      xfer_ptr = {ptr[`CFG_SPACE_BIT], ptr_inc};
    else
      xfer_ptr = ptr;
  end

  // Sequencing of table commands, latch and pointer
  always_comb
  begin
    next_state = state;
    next_latch = latch;
    next_ptr   = sfr_ptr;
    next_mode  = mode;
    next_rd    = '0;
    if (sfr_i.we && sfr_i.addr == `SFR_LATCH)
      next_latch = sfr_i.wdata;
    // A pointer update by the command outweighs a byte write this cycle
    case (state)
      ST_IDLE:
      begin
        if (cmd_i.valid)
        begin
          next_mode = cmd_i.mode;
          if (cmd_i.mode == PTR_PRE_INC)
            next_ptr = xfer_ptr;
          if (cmd_i.is_write)
            next_state = ST_DONE;
          else
          begin
            next_rd.req       = 1'b1;
            next_rd.addr      = xfer_ptr[`ADDR_WIDTH-1:0];
            next_rd.cfg_space = xfer_ptr[`CFG_SPACE_BIT];
            next_state        = ST_READ;
          end
        end
      end
      ST_READ:
      begin
        if (rd_valid_i)
        begin
          next_latch = rd_data_i;
          next_state = ST_DONE;
        end
      end
      ST_DONE:
      begin
        case (mode)
          PTR_POST_INC: next_ptr = {ptr[`CFG_SPACE_BIT], ptr_inc};
          PTR_POST_DEC: next_ptr = {ptr[`CFG_SPACE_BIT], ptr_dec};
          default:      next_ptr = sfr_ptr;
        endcase
        next_state = ST_IDLE;
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  // Holding registers: flash sees them only through a block write
  always_comb
  begin
    next_hold = hold;
    if (hold_write)
      next_hold[hold_sel] = latch;
  end

  // Write bit: software sets, hardware clears on completion; clear wins
  always_comb
  begin
    next_write_bit   = write_bit;
    next_wr          = '0;
    next_erase       = '0;
    if (write_bit && flash_op_done_i)
      next_write_bit = 1'b0;
    // Starts while the bit is set are dropped
    if ((write_start_i || erase_start_i) && !write_bit)
    begin
      next_write_bit = 1'b1;
      if (erase_start_i)
      begin
        next_erase.req       = 1'b1;
        next_erase.block     = block_sel;
        next_erase.cfg_space = ptr[`CFG_SPACE_BIT];
      end
      else
      begin
        next_wr.req       = 1'b1;
        next_wr.block     = block_sel;
        next_wr.cfg_space = ptr[`CFG_SPACE_BIT];
      end
    end
  end

  // Command group registers
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state      <= ST_IDLE;
      latch      <= `LATCH_RESET;
      ptr        <= `PTR_RESET;
      mode       <= PTR_KEEP;
      flash_rd_o <= '0;
    end
    else
    begin
      state      <= next_state;
      latch      <= next_latch;
      ptr        <= next_ptr;
      mode       <= next_mode;
      flash_rd_o <= next_rd;
    end
  end

  // Write bit and block request registers
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      write_bit     <= 1'b0;
      flash_wr_o    <= '0;
      flash_erase_o <= '0;
    end
    else
    begin
      write_bit     <= next_write_bit;
      flash_wr_o    <= next_wr;
      flash_erase_o <= next_erase;
    end
  end

  // Holding registers come up erased
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      for (int i = 0; i < HOLD_COUNT; i++)
        hold[i] <= `HOLD_RESET;
    end
    else
    begin
      hold <= next_hold;
    end
  end

  // Register read back
  always_comb
  begin
    case (sfr_i.addr)
      `SFR_LATCH:     sfr_rdata_o = latch;
      `SFR_PTR_UPPER: sfr_rdata_o = ptr_upper_byte;
      `SFR_PTR_HIGH:  sfr_rdata_o = ptr[15:8];
      `SFR_PTR_LOW:   sfr_rdata_o = ptr[7:0];
      default:        sfr_rdata_o = 8'h00;
    endcase
  end

  // Holding bytes side by side for the block write
  for (genvar g = 0; g < HOLD_COUNT; g++)
  begin : g_hold_out
    assign hold_data_o[g*8 +: 8] = hold[g];
  end

  // Busy and done decode the state directly; write_active_o is the write bit
  assign cmd_busy_o     = (state != ST_IDLE);
  assign cmd_done_o     = (state == ST_DONE);
  assign write_active_o = write_bit;

endmodule

// ### testbench/program_memory_table_access_asserts.sv
// Port checker for the table access unit.
// Assumes one clock, clk_i, and async reset arst_n_i.
`timescale 1ns/1ps
module program_memory_table_access_asserts
  import table_access_pkg::*;
(
  input wire logic          clk_i,
  input wire logic          arst_n_i,
  input wire sfr_req_type   sfr_i,
  input wire logic [7:0]    sfr_rdata_o,
  input wire table_cmd_type cmd_i,
  input wire logic          cmd_busy_o,
  input wire logic          cmd_done_o,
  input wire logic          write_start_i,
  input wire logic          erase_start_i,
  input wire logic          flash_op_done_i,
  input wire logic          write_active_o,
  input wire flash_rd_type  flash_rd_o,
  input wire logic          rd_valid_i,
  input wire logic [7:0]    rd_data_i,
  input wire flash_blk_type flash_wr_o,
  input wire flash_blk_type flash_erase_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  a_read_req: assert property (cmd_i.valid && !cmd_busy_o && !cmd_i.is_write |=> flash_rd_o.req)
    else $error("no read request");
  a_write_cmd: assert property (cmd_i.valid && !cmd_busy_o && cmd_i.is_write |=> cmd_done_o)
    else $error("write command not done");
  a_read_load: assert property (rd_valid_i && cmd_busy_o |=> cmd_done_o
    && (sfr_i.addr != 2'h0 || sfr_rdata_o == $past(rd_data_i))) else $error("latch not loaded");
  a_upper_zero: assert property (sfr_i.addr == 2'h1 |-> sfr_rdata_o[7:6] == 2'b00)
    else $error("upper pointer byte spare bits set");
  a_write_go: assert property (write_start_i && !erase_start_i && !write_active_o
    |=> flash_wr_o.req && !flash_erase_o.req && write_active_o) else $error("write not started");
  a_erase_go: assert property (erase_start_i && !write_active_o
    |=> flash_erase_o.req && !flash_wr_o.req && write_active_o) else $error("erase not started");
  a_bit_clear: assert property (write_active_o && flash_op_done_i |=> !write_active_o)
    else $error("write bit not cleared");
  a_bit_holds: assert property (write_active_o && !flash_op_done_i
    |=> write_active_o && !flash_wr_o.req && !flash_erase_o.req) else $error("write bit lost");
endmodule

bind program_memory_table_access program_memory_table_access_asserts u_asserts (.*);

// ### testbench/flash_model.sv
// Flash stand-in: answers reads lat_i+2 cycles after the request, ends block operations.
// Assumes single-cycle request pulses on clk_i.
`timescale 1ns/1ps
module flash_model
  import table_access_pkg::*;
(
  input  wire logic         clk_i,
  input  wire flash_rd_type rd_i,
  input  wire logic [3:0]   lat_i,
  input  wire logic         op_i,
  output logic              rd_valid_o,
  output logic [7:0]        rd_data_o,
  output logic              done_o
);
  int         rd_cnt = -1;
  int         op_cnt = -1;
  logic [7:0] val;
  initial
  begin
    rd_valid_o = 1'b0;
    rd_data_o  = 8'h5a;
    done_o     = 1'b0;
  end
  always @(posedge clk_i)
  begin
    rd_cnt     <= rd_i.req ? int'(lat_i) : rd_cnt - int'(rd_cnt >= 0);
    op_cnt     <= op_i ? 6 : op_cnt - int'(op_cnt >= 0);
    if (rd_i.req)
      val <= rd_i.addr[7:0] ^ rd_i.addr[15:8] ^ {rd_i.cfg_space, rd_i.addr[20:14]};
    rd_valid_o <= rd_cnt == 0;
    // Data toggles while not valid
    rd_data_o  <= (rd_cnt == 0) ? val : ~rd_data_o;
    done_o     <= op_cnt == 0;
  end
endmodule

// ### testbench/tb_program_memory_table_access.sv
// Self-checking bench for the table access unit.
// Assumes the flash model sits on the read and block ports.
`timescale 1ns/1ps
module tb_program_memory_table_access;
  import table_access_pkg::*;
  logic          clk_i = 0, arst_n_i = 0, write_start_i = 0, erase_start_i = 0;
  logic          flash_op_done_i, rd_valid_i, cmd_busy_o, cmd_done_o, write_active_o;
  logic [7:0]    rd_data_i, sfr_rdata_o;
  logic [3:0]    lat = 0;
  sfr_req_type   sfr_i = '0;
  table_cmd_type cmd_i = '0;
  flash_rd_type  flash_rd_o;
  flash_blk_type flash_wr_o, flash_erase_o;
  logic [255:0]  hold_data_o;
  int            err_count = 0, samples_checked = 0, seed = 32'h1fea;
  program_memory_table_access u_program_memory_table_access (.*);
  flash_model u_flash_model (.clk_i(clk_i), .rd_i(flash_rd_o), .lat_i(lat),
    .op_i(flash_wr_o.req | flash_erase_o.req), .rd_valid_o(rd_valid_i),
    .rd_data_o(rd_data_i), .done_o(flash_op_done_i));
  initial forever #10 clk_i = ~clk_i;
  function automatic logic [21:0] step(logic [21:0] p, logic [3:0] m);
    logic [20:0] d;
    d = (m == 4'b0100) ? 21'h1fffff : {20'h0, m != 4'b0001};
    return {p[21], p[20:0] + d};
  endfunction
  task automatic check(string name, logic [23:0] exp, logic [23:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic sfr(logic [1:0] a, logic [7:0] d, logic we);
    @(negedge clk_i);
    sfr_i = '{we, 1'b0, a, d};
    #1;
  endtask
  task automatic set_ptr(logic [21:0] p);
    sfr(2'h1, {2'b00, p[21:16]}, 1);
    sfr(2'h2, p[15:8], 1);
    sfr(2'h3, p[7:0], 1);
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #400000;
    err_count++;
    close_out();
  end
  initial
  begin
    logic [21:0] p, q, a;
    logic [7:0]  l;
    logic [3:0]  m;
    logic        w;
    repeat (20) @(negedge clk_i);
    arst_n_i = 1;
    // Reset values: registers zero, holding bytes erased, flags low
    for (int r = 0; r < 4; r++)
    begin
      sfr(2'(r), 0, 0);
      check("reset reg", 0, sfr_rdata_o);
    end
    check("reset hold", 1, &hold_data_o);
    check("reset flags", 0, {cmd_busy_o, cmd_done_o, write_active_o});
    for (int i = 0; i < 60; i++)
    begin
      p = $random(seed);
      m = 4'b0001 << ($unsigned($random(seed)) % 4);
      // Wrap corners at both ends of the 21-bit range
      if (i < 4)
        {p[20:0], m} = {{21{i[0]}}, i[0] ? 4'b0010 : 4'b0100};
      w = $random(seed);
      l = $random(seed);
      lat = $random(seed);
      q = step(p, m);
      a = (m == 4'b1000) ? q : p;
      sfr(2'h0, l, 1);
      set_ptr(p);
      @(negedge clk_i);
      sfr_i = '0;
      cmd_i = '{1'b1, w, ptr_mode_type'(m)};
      @(negedge clk_i);
      cmd_i = '0;
      check("busy", 1, cmd_busy_o);
      if (!w)
        check("read req", {1'b1, a[20:0], a[21]}, flash_rd_o);
      for (int t = 0; t < 40 && cmd_done_o !== 1'b1; t++) @(negedge clk_i);
      check("done", 1, cmd_done_o);
      if (w)
        check("hold", l, hold_data_o[{a[4:0], 3'b000} +: 8]);
      else
        check("latch", a[7:0] ^ a[15:8] ^ a[21:14], sfr_rdata_o);
      sfr(2'h1, 0, 0);
      p[21:16] = sfr_rdata_o[5:0];
      sfr(2'h2, 0, 0);
      p[15:8] = sfr_rdata_o;
      sfr(2'h3, 0, 0);
      p[7:0] = sfr_rdata_o;
      check("pointer", q, p);
      check("idle", 0, cmd_busy_o);
    end
    for (int k = 0; k < 2; k++)
    begin
      p = $random(seed);
      set_ptr(p);
      @(negedge clk_i);
      sfr_i = '0;
      {write_start_i, erase_start_i} = k[0] ? 2'b01 : 2'b10;
      @(negedge clk_i);
      // Second start while active is ignored
      {write_start_i, erase_start_i} = 2'b10;
      check("block", {1'b1, p[21:6], p[21]}, k[0] ? flash_erase_o : flash_wr_o);
      check("other req", 0, k[0] ? flash_wr_o.req : flash_erase_o.req);
      check("active", 1, write_active_o);
      @(negedge clk_i);
      write_start_i = 0;
      check("restart", 0, flash_wr_o.req | flash_erase_o.req);
      for (int t = 0; t < 20 && write_active_o !== 1'b0; t++) @(negedge clk_i);
      check("active", 0, write_active_o);
    end
    close_out();
  end
endmodule
